// ===== rtl/sdi_interrupt_bits.sv
// South display engine shared interrupt bits with mask, identity and buffered enable.
`default_nettype none
// Notes on behaviour
// - Reserved bits 31:28 and 23 ignore writes and read zero.
// - Read-only bits show hardware values; writes never change them.
// - Read/clear bits set by events, cleared only by write data ones.
// - Double-buffered first stage takes writes and supplies readback.
// - At update point first stage copies to second, which drives hardware.
// - With arming, transfer waits until arm register is written.
// - Bits 27, 26, 25 pulse on audio power change, ports D, C, B.
// - Bit 24 pulses on any unmasked serial bus controller event.
// - Status is live; unmasked conditions latch; enables select interrupts.
module sdi_interrupt_bits (
	input wire logic i_clk, // 125 MHz clock
	input wire logic i_srst, // Synchronous reset, active high
	input wire logic i_ce, // Clock enable; low freezes all state
	input wire logic i_aud_pwr_d, // Audio power change pulse, port D
	input wire logic i_aud_pwr_c, // Audio power change pulse, port C
	input wire logic i_aud_pwr_b, // Audio power change pulse, port B
	input wire logic [31:0] i_serial_bus_events, // Raw serial bus controller events
	input wire logic [31:0] i_serial_bus_interrupt_mask, // One enables that event
	input wire logic i_mask_we, // Write strobe, condition mask
	input wire logic i_ident_we, // Write strobe, identity (write one to clear)
	input wire logic i_enable_we, // Write strobe, enable first stage
	input wire logic i_arm_we, // Write strobe of the arming register
	input wire logic i_arm_mode, // High: enable update waits for arm write
	input wire logic i_update_point, // Update point pulse, e.g. frame start
	input wire logic [31:0] i_wdata, // Write data for mask, identity and enable strobes
	input wire logic i_north_clear, // North identity bit clear pulse
	output logic [31:0] o_live_condition_status, // Live status, read-only
	output logic [31:0] o_condition_mask, // Mask readback
	output logic [31:0] o_south_interrupt_identity, // Identity readback
	output logic [31:0] o_interrupt_enable_bits, // Enable first-stage readback
	output logic [31:0] o_enable_active, // Enable second stage
	output logic o_north_south_event, // South event bit of north identity
	output logic o_cpu_irq // Interrupt request to processor
);
	logic [31:0] events_d;
	logic [31:0] status_q;
	logic [31:0] mask_q;
	logic [31:0] ident_q;
	logic [31:0] ident_d;
	logic [31:0] en_first_q;
	logic [31:0] en_second_q;
	logic north_q;
	logic irq_q;
	logic ident_any_q;
	sdi_pkg::sdi_arm_t arm_q;
	logic transfer;

	function automatic logic [31:0] impl_only(input logic [31:0] v);
		impl_only = v & sdi_pkg::IMPL_MASK;
	endfunction

	// ----------------------------------------------------------------
	// Event mapping into the shared layout
	// ----------------------------------------------------------------
	always_comb
	begin
		events_d = 32'h0000_0000;
		events_d[sdi_pkg::BIT_AUD_PORT_D] = i_aud_pwr_d;
		events_d[sdi_pkg::BIT_AUD_PORT_C] = i_aud_pwr_c;
		events_d[sdi_pkg::BIT_AUD_PORT_B] = i_aud_pwr_b;
		events_d[sdi_pkg::BIT_SERIAL_BUS] =
			|(i_serial_bus_events & i_serial_bus_interrupt_mask);
	end

	// Live status: sources are pulses, so status is a one-cycle copy.
	always_ff @(posedge i_clk)
	begin
		if (i_srst)
			status_q <= 32'h0000_0000;
		else if (i_ce)
			status_q <= impl_only(events_d);
	end

	always_ff @(posedge i_clk)
	begin
		if (i_srst)
			mask_q <= impl_only(sdi_pkg::MASK_RESET);
		else if (i_ce && i_mask_we)
			mask_q <= impl_only(i_wdata);
	end

	// ----------------------------------------------------------------
	// Identity: set wins over a clear in the same cycle
	// ----------------------------------------------------------------
	always_comb
	begin
		ident_d = ident_q;
		if (i_ident_we)
			ident_d = ident_d & ~i_wdata;
		ident_d = impl_only(ident_d | (events_d & ~mask_q));
	end

	always_ff @(posedge i_clk)
	begin
		if (i_srst)
			ident_q <= sdi_pkg::IDENT_RESET;
		else if (i_ce)
			ident_q <= ident_d;
	end

	// ----------------------------------------------------------------
	// Double-buffered enable with optional arming
	// ----------------------------------------------------------------
	assign transfer = i_update_point && (!i_arm_mode || arm_q == sdi_pkg::SDI_ARMED);

	always_ff @(posedge i_clk)
	begin
		if (i_srst)
			en_first_q <= sdi_pkg::ENABLE_RESET;
		else if (i_ce && i_enable_we)
			en_first_q <= impl_only(i_wdata);
	end

	always_ff @(posedge i_clk)
	begin
		if (i_srst)
			en_second_q <= sdi_pkg::ENABLE_RESET;
		else if (i_ce && transfer)
			en_second_q <= en_first_q;
	end

	always_ff @(posedge i_clk)
	begin
		if (i_srst)
			arm_q <= sdi_pkg::SDI_IDLE;
		else if (i_ce)
		begin
			case (arm_q)
				sdi_pkg::SDI_IDLE: if (i_arm_we) arm_q <= sdi_pkg::SDI_ARMED;
				sdi_pkg::SDI_ARMED: if (transfer) arm_q <= sdi_pkg::SDI_IDLE;
				default: arm_q <= sdi_pkg::SDI_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// North combining: a new south event sets the north bit only once
	// the identity register has been fully drained, so software must
	// clear every south bit before it can see the next one.
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk)
	begin
		if (i_srst)
		begin
			north_q <= 1'b0;
			ident_any_q <= 1'b0;
		end
		else if (i_ce)
		begin
			ident_any_q <= |ident_d;
			if (!ident_any_q && |ident_d)
				north_q <= 1'b1;
			else if (i_north_clear)
				north_q <= 1'b0;
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (i_srst)
			irq_q <= 1'b0;
		else if (i_ce)
			irq_q <= |(ident_d & en_second_q);
	end

	assign o_live_condition_status = status_q;
	assign o_condition_mask = mask_q;
	assign o_south_interrupt_identity = ident_q;
	assign o_interrupt_enable_bits = en_first_q;
	assign o_enable_active = en_second_q;
	assign o_north_south_event = north_q;
	assign o_cpu_irq = irq_q;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	property p_reserved_zero;
		@(posedge i_clk) disable iff (i_srst)
		(ident_q[31:28] == 4'h0) && !ident_q[23] && (mask_q[31:28] == 4'h0) && !en_first_q[23];
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

	property p_status_ro;
		@(posedge i_clk) disable iff (i_srst)
		i_ce |=> status_q == impl_only($past(events_d));
	endproperty
	a_status_ro: assert property (p_status_ro) else $error("status not live");

	property p_clear_one;
		@(posedge i_clk) disable iff (i_srst)
		(i_ce && i_ident_we && i_wdata[25] && !events_d[25]) |=> !ident_q[25];
	endproperty
	a_clear_one: assert property (p_clear_one) else $error("identity not cleared");

	property p_clear_zero;
		@(posedge i_clk) disable iff (i_srst)
		(i_ce && ident_q[26] && !(i_ident_we && i_wdata[26])) |=> ident_q[26];
	endproperty
	a_clear_zero: assert property (p_clear_zero) else $error("identity lost");

	property p_first_stage;
		@(posedge i_clk) disable iff (i_srst)
		(i_ce && i_enable_we) |=> en_first_q == impl_only($past(i_wdata));
	endproperty
	a_first_stage: assert property (p_first_stage) else $error("enable write lost");

	property p_hold;
		@(posedge i_clk) disable iff (i_srst)
		(i_ce && !transfer) |=> $stable(en_second_q);
	endproperty
	a_hold: assert property (p_hold) else $error("second stage moved");

	sequence s_armed;
		i_ce && i_arm_we && arm_q == sdi_pkg::SDI_IDLE;
	endsequence
	property p_arm;
		@(posedge i_clk) disable iff (i_srst)
		s_armed ##1 (i_ce && i_update_point && i_arm_mode) |=> en_second_q == $past(en_first_q);
	endproperty
	a_arm: assert property (p_arm) else $error("armed transfer missing");

	property p_unarmed;
		@(posedge i_clk) disable iff (i_srst)
		(i_arm_mode && arm_q == sdi_pkg::SDI_IDLE && i_ce) |=> $stable(en_second_q);
	endproperty
	a_unarmed: assert property (p_unarmed) else $error("transfer without arm");

	property p_serial;
		@(posedge i_clk) disable iff (i_srst)
		(i_ce && |(i_serial_bus_events & i_serial_bus_interrupt_mask)) |=> status_q[24];
	endproperty
	a_serial: assert property (p_serial) else $error("serial bit missing");

	property p_audio;
		@(posedge i_clk) disable iff (i_srst)
		(i_ce && i_aud_pwr_d && !mask_q[27]) |=> ident_q[27] && status_q[27];
	endproperty
	a_audio: assert property (p_audio) else $error("audio D not latched");

	property p_north;
		@(posedge i_clk) disable iff (i_srst)
		(i_ce && !ident_any_q && |ident_d) |=> north_q;
	endproperty
	a_north: assert property (p_north) else $error("north bit not set");

	property p_irq;
		@(posedge i_clk) disable iff (i_srst)
		i_ce |=> o_cpu_irq == |($past(ident_d) & $past(en_second_q));
	endproperty
	a_irq: assert property (p_irq) else $error("irq mismatch");
endmodule // sdi_interrupt_bits
`default_nettype wire

// ===== rtl/sdi_pkg.sv
// Package of bit positions, reset values and widths for the south display interrupt block.
`default_nettype none
package sdi_pkg;
	// ----------------------------------------------------------------
	// Shared bit layout
	// ----------------------------------------------------------------
	localparam int unsigned REG_W = 32;
	localparam int unsigned BIT_AUD_PORT_D = 27;
	localparam int unsigned BIT_AUD_PORT_C = 26;
	localparam int unsigned BIT_AUD_PORT_B = 25;
	localparam int unsigned BIT_SERIAL_BUS = 24;
	// Bits that hold storage; 31:28 and 23 are reserved and stay zero.
	localparam logic [31:0] IMPL_MASK = 32'h0f00_0000;
	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [31:0] MASK_RESET = 32'hfffe_dfff;
	localparam logic [31:0] ENABLE_RESET = 32'h0000_0000;
	localparam logic [31:0] IDENT_RESET = 32'h0000_0000;
	// ----------------------------------------------------------------
	// Arming states of the double-buffered enable register
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		SDI_IDLE = 2'b01,
		SDI_ARMED = 2'b10
	} sdi_arm_t;
endpackage
`default_nettype wire

// ===== verif/sdi_north_model.sv
// Model of the north engine logic that services the south event bit.
`default_nettype none
module sdi_north_model (
	input wire logic i_clk, // Clock
	input wire logic i_srst, // Synchronous reset, active high
	input wire logic i_north_event, // South event bit of north identity
	input wire logic i_service, // Level request to acknowledge the event
	output logic o_north_clear, // Clear pulse to the south block
	output logic [7:0] o_seen // Rising edges of the event bit
);
	timeunit 1ns;
	timeprecision 1ps;
	logic event_q;
	// Clearing early, while identity bits remain, shows the bit is not raised again.
	always_ff @(posedge i_clk)
	begin
		if (i_srst)
		begin
			o_north_clear <= 1'b0;
			event_q <= 1'b0;
			o_seen <= 8'h00;
		end
		else
		begin
			o_north_clear <= i_service && i_north_event && !o_north_clear;
			event_q <= i_north_event;
			if (i_north_event && !event_q)
				o_seen <= o_seen + 8'h01;
		end
	end
endmodule // sdi_north_model
`default_nettype wire

// ===== verif/tb_sdi_interrupt_bits.sv
// Self-checking testbench of the south display interrupt bits block.
`default_nettype none
module tb_sdi_interrupt_bits;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_clk = 1'b0;
	logic i_srst = 1'b1;
	logic ce = 1'b1;
	logic arm_mode = 1'b0;
	logic service = 1'b0;
	logic [7:0] pls = 8'h00;
	logic [31:0] wdata = 32'h0, sev = 32'h0, sbmask = 32'h0, exp_id;
	logic [31:0] st, mk, id, en, act;
	logic north, irq, nclr;
	logic [7:0] seen;
	int n_errors = 0;
	int total_checks = 0;
	int cycles = 0;
	always #4 i_clk = ~i_clk;
	sdi_interrupt_bits DUT (.i_clk(i_clk), .i_srst(i_srst), .i_ce(ce),
		.i_aud_pwr_d(pls[7]), .i_aud_pwr_c(pls[6]), .i_aud_pwr_b(pls[5]),
		.i_serial_bus_events(sev), .i_serial_bus_interrupt_mask(sbmask),
		.i_mask_we(pls[0]), .i_ident_we(pls[1]), .i_enable_we(pls[2]), .i_arm_we(pls[3]),
		.i_arm_mode(arm_mode), .i_update_point(pls[4]), .i_wdata(wdata),
		.i_north_clear(nclr), .o_live_condition_status(st), .o_condition_mask(mk),
		.o_south_interrupt_identity(id), .o_interrupt_enable_bits(en),
		.o_enable_active(act), .o_north_south_event(north), .o_cpu_irq(irq));
	sdi_north_model north_side (.i_clk(i_clk), .i_srst(i_srst), .i_north_event(north),
		.i_service(service), .o_north_clear(nclr), .o_seen(seen));
	task automatic chk(input logic [31:0] seen_v, input logic [31:0] exp_v);
		total_checks++;
		if (seen_v !== exp_v)
		begin
			n_errors++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen_v, exp_v);
		end
	endtask
	// One strobe set per call; the values are taken at the second edge.
	task automatic go(input logic [7:0] p, input logic [31:0] d, input logic [31:0] se);
		@(posedge i_clk);
		pls <= p;
		wdata <= d;
		sev <= se;
		@(posedge i_clk);
		pls <= 8'h00;
		sev <= 32'h0;
		#1;
	endtask
	task automatic final_report;
		$display("checks %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	always @(posedge i_clk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			n_errors++;
			final_report();
		end
	end
	initial
	begin
		repeat (4) @(posedge i_clk);
		i_srst <= 1'b0;
		#1;
		chk(mk, 32'h0f00_0000);
		chk(id | en | act | st, 32'h0);
		go(8'h01, 32'hffff_ffff, 32'h0);
		chk(mk, 32'h0f00_0000);
		chk(st, 32'h0);
		go(8'h04, 32'hffff_ffff, 32'h0);
		chk(en, 32'h0f00_0000);
		go(8'h01, 32'h0200_0000, 32'h0);
		go(8'h20, 32'h0, 32'h0);
		chk(st, 32'h0200_0000);
		chk(id, 32'h0);
		go(8'h01, 32'h0, 32'h0);
		@(posedge i_clk);
		ce <= 1'b0;
		go(8'h01, 32'h0f00_0000, 32'h0);
		chk(mk, 32'h0);
		@(posedge i_clk);
		ce <= 1'b1;
		$display("test reserved and mask done");
		exp_id = 32'h0;
		for (int i = 0; i < 3; i++)
		begin
			go(8'h20 << i, 32'h0, 32'h0);
			exp_id = exp_id | (32'h0200_0000 << i);
			chk(st, 32'h0200_0000 << i);
			chk(id, exp_id);
		end
		@(posedge i_clk);
		sbmask <= 32'h0000_0010;
		go(8'h00, 32'h0, 32'h0000_0001);
		chk(st, 32'h0);
		go(8'h00, 32'h0, 32'h0000_0010);
		chk(st, 32'h0100_0000);
		chk(id, 32'h0f00_0000);
		@(posedge i_clk);
		#1;
		chk(st, 32'h0);
		chk({31'h0, north}, 32'h1);
		chk({24'h0, seen}, 32'h1);
		@(posedge i_clk);
		service <= 1'b1;
		repeat (3) @(posedge i_clk);
		service <= 1'b0;
		#1;
		chk({31'h0, north}, 32'h0);
		go(8'h80, 32'h0, 32'h0);
		chk({31'h0, north}, 32'h0);
		go(8'h02, 32'h0, 32'h0);
		chk(id, 32'h0f00_0000);
		go(8'h02, 32'h0100_0000, 32'h0);
		chk(id, 32'h0e00_0000);
		go(8'h02, 32'hffff_ffff, 32'h0);
		chk(id, 32'h0);
		go(8'h40, 32'h0, 32'h0);
		chk({31'h0, north}, 32'h1);
		// The north model counts the new edge one clock after the block raises it.
		@(posedge i_clk);
		#1;
		chk({24'h0, seen}, 32'h2);
		$display("test events and identity done");
		go(8'h04, 32'h0400_0000, 32'h0);
		chk(en, 32'h0400_0000);
		chk(act, 32'h0);
		go(8'h10, 32'h0, 32'h0);
		chk(act, 32'h0400_0000);
		@(posedge i_clk);
		#1;
		chk({31'h0, irq}, 32'h1);
		@(posedge i_clk);
		arm_mode <= 1'b1;
		go(8'h04, 32'h0800_0000, 32'h0);
		go(8'h10, 32'h0, 32'h0);
		chk(act, 32'h0400_0000);
		go(8'h08, 32'h0, 32'h0);
		go(8'h10, 32'h0, 32'h0);
		chk(act, 32'h0800_0000);
		go(8'h04, 32'h0, 32'h0);
		go(8'h10, 32'h0, 32'h0);
		chk(act, 32'h0800_0000);
		chk(en, 32'h0);
		@(posedge i_clk);
		#1;
		chk({31'h0, irq}, 32'h0);
		// Arm write and update point on adjacent edges: the transfer happens at once.
		@(posedge i_clk);
		pls <= 8'h08;
		@(posedge i_clk);
		pls <= 8'h10;
		@(posedge i_clk);
		pls <= 8'h00;
		#1;
		chk(act, 32'h0);
		$display("test buffered enable done");
		final_report();
	end
endmodule // tb_sdi_interrupt_bits
`default_nettype wire
